// *** inc/stp_pkg.sv ***
// stp_pkg: constants and types for the scan test port block
// assumes: included before rtl/stp_*.sv, nothing imported
package stp_pkg;

  // ****************************************
  // tap states
  // ****************************************
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } stp_tap_type;

  // ****************************************
  // widths, instruction codes, bit positions and reset values
  // ****************************************
  localparam int          IR_W         = 4;
  localparam int          SCAN_W       = 8;
  localparam logic [3:0]  IR_CAPTURE   = 4'h1;
  localparam logic [3:0]  IR_RESET     = 4'hF;
  localparam logic [3:0]  IR_BYPASS    = 4'hF;
  localparam logic [3:0]  IR_SCAN      = 4'h2;
  localparam int          DIR_EMULATOR_EVENT_LINE_ZERO_BIT = 0;
  localparam int          DIR_EMU1_BIT = 1;
  localparam logic [7:0]  SCAN_RESET   = 8'h00;

endpackage : stp_pkg

// *** rtl/stp_sync2.sv ***
// stp_sync2: two flip-flop level synchroniser
// assumes: input is asynchronous to clk_i
`timescale 1ns/1ps
module stp_sync2 (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // level
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule : stp_sync2

// *** rtl/stp_port.sv ***
// stp_port: scan test access port with emulator event / output float pins
// assumes: tck_i from external controller, core_clk_i for core side
`timescale 1ns/1ps
module stp_port #(
  parameter int SCAN_W = stp_pkg::SCAN_W
) (
  // core clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // test access port
  input  wire logic              tck_i,
  input  wire logic              tms_i,
  input  wire logic              tdi_i,
  input  wire logic              trst_i,
  output logic                   tdo_o,
  output logic                   tdo_oe_o,
  // emulator pins
  input  wire logic              emulator_event_line_zero_i,
  output logic                   emulator_event_line_zero_o,
  output logic                   emulator_event_line_zero_oe_o,
  input  wire logic              emulator_event_or_float_pin_i,
  output logic                   emulator_event_or_float_pin_o,
  output logic                   emulator_event_or_float_pin_oe_o,
  // core side
  input  wire logic              core_evt0_i,
  input  wire logic              core_evt1_i,
  output logic                   core_evt0_o,
  output logic                   core_evt1_o,
  output logic                   scan_mode_o,
  output logic                   float_all_o,
  output logic [SCAN_W-1:0]      scan_ctl_o
);

  // ****************************************
  // tck domain state
  // ****************************************
  typedef struct packed {
    stp_pkg::stp_tap_type      tap;
    logic [stp_pkg::IR_W-1:0]  ir_sh;
    logic [stp_pkg::IR_W-1:0]  ir;
    logic [SCAN_W-1:0]         dr_sh;
    logic [SCAN_W-1:0]         dr;
    logic                      byp;
    logic                      upd;
  } stp_tck_type;

  typedef struct packed {
    logic tdo;
    logic oe;
  } stp_neg_type;

  stp_tck_type tck_ff;
  stp_tck_type nxt_tck;
  stp_neg_type neg_ff;
  stp_neg_type nxt_neg;

  logic tap_rst_n;
  logic float_n;
  logic scan_sel;

  // trst low holds tap in reset and ignores scan inputs
  assign tap_rst_n = trst_i;
  // float control only while trst low, line zero high and pin one low
  assign float_n   = ~(~trst_i & emulator_event_line_zero_i
                       & ~emulator_event_or_float_pin_i);
  assign scan_sel  = (tck_ff.ir == stp_pkg::IR_SCAN);

  // ****************************************
  // rising edge: tap and registers
  // ****************************************
  always_comb begin
    nxt_tck = tck_ff;
    case (tck_ff.tap)
      stp_pkg::TLR:    nxt_tck.tap = tms_i ? stp_pkg::TLR    : stp_pkg::RTI;
      stp_pkg::RTI:    nxt_tck.tap = tms_i ? stp_pkg::SEL_DR : stp_pkg::RTI;
      stp_pkg::SEL_DR: nxt_tck.tap = tms_i ? stp_pkg::SEL_IR : stp_pkg::CAP_DR;
      stp_pkg::CAP_DR: nxt_tck.tap = tms_i ? stp_pkg::EX1_DR : stp_pkg::SHF_DR;
      stp_pkg::SHF_DR: nxt_tck.tap = tms_i ? stp_pkg::EX1_DR : stp_pkg::SHF_DR;
      stp_pkg::EX1_DR: nxt_tck.tap = tms_i ? stp_pkg::UPD_DR : stp_pkg::PAU_DR;
      stp_pkg::PAU_DR: nxt_tck.tap = tms_i ? stp_pkg::EX2_DR : stp_pkg::PAU_DR;
      stp_pkg::EX2_DR: nxt_tck.tap = tms_i ? stp_pkg::UPD_DR : stp_pkg::SHF_DR;
      stp_pkg::UPD_DR: nxt_tck.tap = tms_i ? stp_pkg::SEL_DR : stp_pkg::RTI;
      stp_pkg::SEL_IR: nxt_tck.tap = tms_i ? stp_pkg::TLR    : stp_pkg::CAP_IR;
      stp_pkg::CAP_IR: nxt_tck.tap = tms_i ? stp_pkg::EX1_IR : stp_pkg::SHF_IR;
      stp_pkg::SHF_IR: nxt_tck.tap = tms_i ? stp_pkg::EX1_IR : stp_pkg::SHF_IR;
      stp_pkg::EX1_IR: nxt_tck.tap = tms_i ? stp_pkg::UPD_IR : stp_pkg::PAU_IR;
      stp_pkg::PAU_IR: nxt_tck.tap = tms_i ? stp_pkg::EX2_IR : stp_pkg::PAU_IR;
      stp_pkg::EX2_IR: nxt_tck.tap = tms_i ? stp_pkg::UPD_IR : stp_pkg::SHF_IR;
      stp_pkg::UPD_IR: nxt_tck.tap = tms_i ? stp_pkg::SEL_DR : stp_pkg::RTI;
      default:         nxt_tck.tap = stp_pkg::TLR;
    endcase
    case (tck_ff.tap)
      stp_pkg::TLR: begin
        nxt_tck.ir = stp_pkg::IR_RESET;
        nxt_tck.dr = SCAN_W'(stp_pkg::SCAN_RESET);
      end
      stp_pkg::CAP_IR: nxt_tck.ir_sh = stp_pkg::IR_CAPTURE;
      stp_pkg::SHF_IR: nxt_tck.ir_sh = {tdi_i, tck_ff.ir_sh[stp_pkg::IR_W-1:1]};
      stp_pkg::UPD_IR: nxt_tck.ir = tck_ff.ir_sh;
      stp_pkg::CAP_DR: begin
        nxt_tck.dr_sh = tck_ff.dr;
        nxt_tck.byp   = 1'b0;
      end
      stp_pkg::SHF_DR: begin
        if (scan_sel) begin
          nxt_tck.dr_sh = {tdi_i, tck_ff.dr_sh[SCAN_W-1:1]};
        end else begin
          nxt_tck.byp = tdi_i;
        end
      end
      stp_pkg::UPD_DR: begin
        if (scan_sel) begin
          nxt_tck.dr = tck_ff.dr_sh;
        end
      end
      default: ;
    endcase
    // toggle marks every change of the scan word for the core side
    if (nxt_tck.dr != tck_ff.dr) begin
      nxt_tck.upd = ~tck_ff.upd;
    end
  end

  always_ff @(posedge tck_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tck_ff <= '{tap: stp_pkg::TLR, ir_sh: stp_pkg::IR_RESET, ir: stp_pkg::IR_RESET,
                  dr_sh: SCAN_W'(stp_pkg::SCAN_RESET), dr: SCAN_W'(stp_pkg::SCAN_RESET),
                  byp: 1'b0, upd: 1'b0};
    end else begin
      tck_ff <= nxt_tck;
    end
  end

  // ****************************************
  // falling edge: tdo
  // ****************************************
  always_comb begin
    nxt_neg = '{tdo: 1'b0, oe: 1'b0};
    if (tck_ff.tap == stp_pkg::SHF_IR) begin
      nxt_neg.tdo = tck_ff.ir_sh[0];
      nxt_neg.oe  = 1'b1;
    end else if (tck_ff.tap == stp_pkg::SHF_DR) begin
      nxt_neg.tdo = scan_sel ? tck_ff.dr_sh[0] : tck_ff.byp;
      nxt_neg.oe  = 1'b1;
    end
  end

  always_ff @(negedge tck_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      neg_ff <= '{tdo: 1'b0, oe: 1'b0};
    end else begin
      neg_ff <= nxt_neg;
    end
  end

  assign tdo_o    = neg_ff.tdo;
  assign tdo_oe_o = neg_ff.oe & float_n;

  // ****************************************
  // emulator pins
  // ****************************************
  assign emulator_event_line_zero_o        = core_evt0_i;
  assign emulator_event_line_zero_oe_o     = trst_i
                                             & tck_ff.dr[stp_pkg::DIR_EMULATOR_EVENT_LINE_ZERO_BIT];
  assign emulator_event_or_float_pin_o     = core_evt1_i;
  assign emulator_event_or_float_pin_oe_o  = trst_i
                                             & tck_ff.dr[stp_pkg::DIR_EMU1_BIT];

  // ****************************************
  // core domain crossing
  // ****************************************
  logic trst_s;
  logic flt_s;
  logic e0_s;
  logic e1_s;
  logic e0_in;
  logic e1_in;
  logic upd_s;

  assign e0_in = emulator_event_line_zero_i & ~emulator_event_line_zero_oe_o;
  assign e1_in = emulator_event_or_float_pin_i & ~emulator_event_or_float_pin_oe_o;

  stp_sync2 u_sync_trst (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .d_i(trst_i), .q_o(trst_s));
  stp_sync2 u_sync_flt  (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .d_i(~float_n), .q_o(flt_s));
  stp_sync2 u_sync_e0   (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .d_i(e0_in), .q_o(e0_s));
  stp_sync2 u_sync_e1   (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .d_i(e1_in), .q_o(e1_s));
  stp_sync2 u_sync_upd  (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .d_i(tck_ff.upd), .q_o(upd_s));

  typedef struct packed {
    logic              mode;
    logic              flt;
    logic              ev0;
    logic              ev1;
    logic [SCAN_W-1:0] ctl;
    logic              upd;
  } stp_core_type;

  stp_core_type core_ff;
  stp_core_type nxt_core;

  always_comb begin
    nxt_core      = core_ff;
    nxt_core.mode = trst_s;
    nxt_core.flt  = flt_s;
    nxt_core.ev0  = trst_s & e0_s;
    nxt_core.ev1  = trst_s & e1_s;
    nxt_core.upd  = upd_s;
    // scan word taken only after its change toggle passed two flops;
    // the word must stand at least three core cycles between changes
    if (!trst_s) begin
      nxt_core.ctl = SCAN_W'(stp_pkg::SCAN_RESET);
    end else if (upd_s != core_ff.upd) begin
      nxt_core.ctl = tck_ff.dr;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      core_ff <= '0;
    end else begin
      core_ff <= nxt_core;
    end
  end

  assign scan_mode_o = core_ff.mode;
  assign float_all_o = core_ff.flt;
  assign core_evt0_o = core_ff.ev0;
  assign core_evt1_o = core_ff.ev1;
  assign scan_ctl_o  = core_ff.ctl;

  // ****************************************
  // assertions
  // ****************************************
  a_tdo_float_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!float_n) |-> !tdo_oe_o) else $error("tdo driven while float active");
  a_tdo_idle_off: assert property (@(posedge tck_i) disable iff (!trst_i)
    (tck_ff.tap == stp_pkg::TLR) |-> !neg_ff.oe) else $error("tdo driven in reset");
  a_shift_ir_out: assert property (@(negedge tck_i) disable iff (!trst_i)
    (tck_ff.tap == stp_pkg::SHF_IR) |=> (neg_ff.tdo == $past(tck_ff.ir_sh[0])))
    else $error("ir bit not shifted out");
  a_tms_reset5: assert property (@(posedge tck_i) disable iff (!trst_i)
    tms_i [*5] |=> (tck_ff.tap == stp_pkg::TLR)) else $error("tap missed reset");
  a_emu_no_drive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !trst_i |-> !emulator_event_line_zero_oe_o) else $error("line zero driven in func");
  a_emu1_no_drive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !trst_i |-> !emulator_event_or_float_pin_oe_o) else $error("pin one driven in func");
  a_mode_follow: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(trst_i) ##1 trst_i [*3] |=> scan_mode_o) else $error("scan mode not entered");
  a_func_ctl_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !trst_i [*4] |=> (scan_ctl_o == stp_pkg::SCAN_RESET)) else $error("scan ctl in func");

  // ****************************************
  // shift path and tap reset checks
  // ****************************************
  a_shift_dr_out: assert property (@(negedge tck_i) disable iff (!trst_i)
    (tck_ff.tap == stp_pkg::SHF_DR && scan_sel) |=> (neg_ff.tdo == $past(tck_ff.dr_sh[0])))
    else $error("scan bit not shifted out");
  a_bypass_out: assert property (@(negedge tck_i) disable iff (!trst_i)
    (tck_ff.tap == stp_pkg::SHF_DR && !scan_sel) |=> (neg_ff.tdo == $past(tck_ff.byp)))
    else $error("bypass bit not shifted out");
  a_tdo_shift_on: assert property (@(negedge tck_i) disable iff (!trst_i)
    (tck_ff.tap == stp_pkg::SHF_DR || tck_ff.tap == stp_pkg::SHF_IR) |=> neg_ff.oe)
    else $error("tdo not driven while shifting");
  a_tdo_rest_off: assert property (@(negedge tck_i) disable iff (!trst_i)
    !(tck_ff.tap == stp_pkg::SHF_DR || tck_ff.tap == stp_pkg::SHF_IR) |=> !neg_ff.oe)
    else $error("tdo driven outside shift");
  a_tap_held_rst: assert property (@(posedge tck_i)
    !trst_i [*2] |-> (tck_ff.tap == stp_pkg::TLR)) else $error("tap left reset with trst low");

  // ****************************************
  // core side checks
  // ****************************************
  a_mode_drop: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !trst_i [*4] |=> !scan_mode_o) else $error("scan mode kept without trst");
  a_evt_func_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !trst_i [*4] |=> (!core_evt0_o && !core_evt1_o)) else $error("event passed in func");
  a_evt0_pass: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (trst_i && e0_in) [*4] |=> core_evt0_o) else $error("line zero event lost");
  a_evt1_pass: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (trst_i && e1_in) [*4] |=> core_evt1_o) else $error("pin one event lost");
  a_float_follow: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!float_n) [*4] |=> float_all_o) else $error("float not taken");
  a_float_release: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    float_n [*4] |=> !float_all_o) else $error("float not released");

endmodule : stp_port

// *** testbench/stp_ctl_model.sv ***
// stp_ctl_model: external scan controller driving the test access port
// assumes: tck stands low between frames, half period 7.5 ns
`timescale 1ns/1ps
module stp_ctl_model (
  // test access port
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  // observation
  output logic      moved_o
);
  // ****************************************
  // idle levels and tdo watch
  // ****************************************
  initial begin
    tck_o   = 1'b0;
    tms_o   = 1'b1;
    tdi_o   = 1'b1;
    trst_o  = 1'b0;
    moved_o = 1'b0;
  end
  always @(tdo_i or tdo_oe_i) begin
    if (tck_o === 1'b1) begin
      moved_o = 1'b1;
    end
  end
  // ****************************************
  // frame tasks
  // ****************************************
  task automatic set_trst(input logic v);
    trst_o = v;
    #15;
  endtask : set_trst
  // tms and tdi change while tck is low, tdo is taken at the rising edge
  task automatic bit_cyc(input logic tms, input logic tdi, output logic tdo, output logic oe);
    tms_o = tms;
    tdi_o = tdi;
    #7.5 tck_o = 1'b1;
    tdo = tdo_i;
    oe  = tdo_oe_i;
    #7.5 tck_o = 1'b0;
  endtask : bit_cyc
  // from run test idle through one shift, back to run test idle
  task automatic shift_reg(input logic ir, input int n, input logic [7:0] din,
                           output logic [7:0] dout, output logic oe_in, output logic oe_out);
    logic t;
    logic o;
    dout  = 8'h00;
    oe_in = 1'b1;
    bit_cyc(1'b0, 1'b0, t, o);
    bit_cyc(1'b1, 1'b0, t, o);
    if (ir) begin
      bit_cyc(1'b1, 1'b0, t, o);
    end
    bit_cyc(1'b0, 1'b0, t, o);
    bit_cyc(1'b0, 1'b0, t, o);
    for (int i = 0; i < n; i++) begin
      bit_cyc(i == n - 1, din[i], dout[i], o);
      oe_in = oe_in & o;
    end
    bit_cyc(1'b1, 1'b0, t, o);
    bit_cyc(1'b0, 1'b0, t, oe_out);
  endtask : shift_reg
endmodule : stp_ctl_model

// *** testbench/testbench.sv ***
// testbench: scan port scenarios in functional, float and scan modes
// assumes: stp_pkg compiled first, controller model drives the tap
`timescale 1ns/1ps
module testbench;
  logic       core_clk_i, rst_n_i, tck, tms, tdi, trst, tdo, tdo_oe, moved;
  logic       e0_i, e0_o, e0_oe, e1_i, e1_o, e1_oe, e0_drv, e1_drv, evt0, evt1;
  logic       evt0_o, evt1_o, scan_mode, float_all, oe_in, oe_out;
  logic [7:0] scan_ctl, dout;
  int         err_total, check_count, cycles;
  // ****************************************
  // pins, clock and instances
  // ****************************************
  assign e0_i = e0_oe ? e0_o : e0_drv;
  assign e1_i = e1_oe ? e1_o : e1_drv;
  always #4 core_clk_i = ~core_clk_i;
  stp_ctl_model ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_o(trst),
                     .tdo_i(tdo), .tdo_oe_i(tdo_oe), .moved_o(moved));
  stp_port dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .trst_i(trst), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .emulator_event_line_zero_i(e0_i), .emulator_event_line_zero_o(e0_o),
    .emulator_event_line_zero_oe_o(e0_oe), .emulator_event_or_float_pin_i(e1_i),
    .emulator_event_or_float_pin_o(e1_o), .emulator_event_or_float_pin_oe_o(e1_oe),
    .core_evt0_i(evt0), .core_evt1_i(evt1), .core_evt0_o(evt0_o), .core_evt1_o(evt1_o),
    .scan_mode_o(scan_mode), .float_all_o(float_all), .scan_ctl_o(scan_ctl));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t %s", $time, what);
    end
  endtask : check
  task automatic pins(input logic z, input logic o);
    @(posedge core_clk_i);
    e0_drv <= z;
    e1_drv <= o;
    repeat (6) @(posedge core_clk_i);
  endtask : pins
  task automatic results();
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_functional();
    pins(1'b0, 1'b1);
    ctl.shift_reg(1'b1, 4, 8'h02, dout, oe_in, oe_out);
    check(oe_in, 1'b0, "tdo driven in functional mode");
    check(scan_mode, 1'b0, "scan mode without trst");
    check(float_all, 1'b0, "float with line zero low");
  endtask : t_functional
  task automatic t_float();
    pins(1'b1, 1'b0);
    check(float_all, 1'b1, "float not taken");
    check(tdo_oe, 1'b0, "tdo driven under float");
    pins(1'b1, 1'b1);
    check(float_all, 1'b0, "float not released");
  endtask : t_float
  task automatic t_scan();
    ctl.set_trst(1'b1);
    @(posedge core_clk_i);
    evt0 <= 1'b1;
    evt1 <= 1'b0;
    pins(1'b0, 1'b1);
    check(scan_mode, 1'b1, "scan mode not entered");
    ctl.shift_reg(1'b0, 8, 8'h03, dout, oe_in, oe_out);
    check(dout, 8'h06, "bypass delay wrong");
    ctl.shift_reg(1'b1, 4, 8'h02, dout, oe_in, oe_out);
    check(dout[3:0], 4'h1, "instruction capture out");
    check({oe_in, oe_out}, 2'h2, "tdo enable around shift");
    ctl.shift_reg(1'b0, 8, 8'h03, dout, oe_in, oe_out);
    pins(1'b0, 1'b1);
    check(scan_ctl, 8'h03, "scan register update");
    check({e0_oe, e0_o}, 2'h3, "line zero drive");
    check({e1_oe, e1_o}, 2'h2, "pin one drive");
    ctl.shift_reg(1'b0, 8, 8'h00, dout, oe_in, oe_out);
    check(dout, 8'h03, "scan register read back");
    pins(1'b0, 1'b1);
    check({e0_oe, evt0_o}, 2'h0, "line zero input");
    check({e1_oe, evt1_o}, 2'h1, "pin one input");
    check(moved, 1'b0, "tdo moved with tck high");
    ctl.set_trst(1'b0);
    pins(1'b0, 1'b1);
    check(scan_ctl, 8'h00, "scan control kept after trst low");
  endtask : t_scan
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    core_clk_i  = 1'b0;
    rst_n_i     = 1'b0;
    e0_drv      = 1'b0;
    e1_drv      = 1'b1;
    evt0        = 1'b0;
    evt1        = 1'b0;
    err_total   = 0;
    check_count = 0;
    cycles      = 0;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_functional();
    t_float();
    t_scan();
    results();
  end
endmodule : testbench
